//--- wdcm_top.sv
// Windowed watchdog and clock monitor with Avalon-MM register access
// Function
// - Watchdog and monitor active from reset
// - Reset leaves 64k window, monitor enabled
// - One keyed configuring write fixes settings
// - Later writes compare window, key, monitor
// - Matching write restarts service window
// - Any field mismatch raises watchdog fault
// - Upper limit expiry raises watchdog fault
// - Service before 2048 cycles is fault
// - Configuring write counts as service
// - First service free of lower limit
// - Drive pin low, hold 16-32 after low
// - Window restarts when pin returns high
// - Services ignored while fault active
// - Pin low at power-up times out
// - Slow clock drives pin, release after hold
// - Never flag over 10 kHz, always below 10 Hz
// - Key field reads back as zeros
// - Watchdog suspended in halt and idle
// - Clock monitor stays active in halt
// - RC option without delay resumes count
// - Crystal or delay restarts window after halt
// - Idle exit performs hardware service
// - Window code selects 8k to 64k limit
// - Key 01100 in bits 5..1, monitor bit 0
//
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
module wdcm_top #(
	parameter int CM_CYC_P = wdcm_pkg::CM_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        inst_clk_i,
	input  wire logic        fault_pin_i,
	output logic             fault_pin_o,
	output logic             fault_pin_oe
);
	import wdcm_pkg::*;

	localparam int CMW = $clog2(CM_CYC_P + 1);
	localparam logic [CMW-1:0] CM_MAX = CMW'(CM_CYC_P);

	// Upper limit for a window code
	function automatic logic [16:0] upper_lim(input logic [1:0] code);
		upper_lim = UPPER_BASE << code;
	endfunction : upper_lim

	logic           wait_ff;
	logic [31:0]    rdata_ff;
	logic           ic_s1_ff, ic_s2_ff, ic_s3_ff;
	logic           pin_s1_ff, pin_s2_ff;
	logic [1:0]     win_ff;
	logic           cm_en_ff;
	logic           cfg_ff;
	logic [3:0]     ctl_ff;
	logic [16:0]    cnt_ff;
	wdcm_wd_t       wd_ff;
	wdcm_wd_t       nxt_wd;
	logic [4:0]     wd_hold_ff;
	wdcm_cm_t       cm_ff;
	wdcm_cm_t       nxt_cm;
	logic [4:0]     cm_hold_ff;
	logic [CMW-1:0] gap_ff;
	logic           oe_ff;
	logic           pin_o_ff;

	logic tick, pin_low, acc, acc_wr, svc_wr, ctl_wr, key_ok, svc_ok;
	logic svc_err, svc_valid, susp, halt_exit, idle_exit, restart;
	logic cm_slow, timeout;
	logic [16:0] lim;

	assign avs_readdata    = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign fault_pin_oe    = oe_ff;
	assign fault_pin_o     = pin_o_ff;

	// Bus strobes: an access completes in the cycle waitrequest is low
	assign acc    = (avs_read | avs_write) & ~wait_ff;
	assign acc_wr = acc & avs_write & avs_byteenable[0];
	assign ctl_wr = acc_wr & (avs_address == OFS_CTL);
	// Services while the watchdog drives the pin or waits for it high are dropped
	assign svc_wr = acc_wr & (avs_address == OFS_SVC) & (wd_ff == WD_RUN);

	// Timing base and pin level
	assign tick    = ic_s2_ff & ~ic_s3_ff;
	assign pin_low = ~pin_s2_ff;
	assign susp    = ctl_ff[CTL_HALT] | ctl_ff[CTL_IDLE];
	assign lim     = upper_lim(win_ff);
	assign timeout = cnt_ff >= lim;
	assign cm_slow = gap_ff == CM_MAX;

	// Service check
	always_comb
	begin
		key_ok = avs_writedata[SVC_KEY_LSB +: 5] == SVC_KEY;
		if (!cfg_ff)
			svc_ok = key_ok;
		else
			svc_ok = key_ok && (avs_writedata[SVC_WIN_LSB +: 2] == win_ff)
				&& (avs_writedata[SVC_CM_BIT] == cm_en_ff)
				&& (cnt_ff >= LOWER_TC);
		svc_err   = svc_wr & ~svc_ok;
		svc_valid = svc_wr & svc_ok;
	end

	// Low-power exits decoded from control writes
	assign halt_exit = ctl_wr & ctl_ff[CTL_HALT] & ~avs_writedata[CTL_HALT];
	assign idle_exit = ctl_wr & ctl_ff[CTL_IDLE] & ~avs_writedata[CTL_IDLE];
	// RC without delay resumes; crystal or delay restarts
	assign restart = svc_valid | idle_exit
		| (halt_exit & (ctl_ff[CTL_XTAL] | ctl_ff[CTL_CLOCK_DELAY_SEL]))
		| ((wd_ff == WD_WAITHI) & ~pin_low);

	// Bus handshake: one wait cycle, then a single ready cycle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			wait_ff <= 1'b1;
		else if (ce)
			wait_ff <= ~((avs_read | avs_write) & wait_ff);
	end

	// Read data captured while the request waits; key bits read as zero
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata_ff <= 32'h0;
		else if (ce && avs_read && wait_ff)
		begin
			rdata_ff <= 32'h0;
			if (avs_address == OFS_SVC)
			begin
				rdata_ff[SVC_WIN_LSB +: 2] <= win_ff;
				rdata_ff[SVC_CM_BIT]       <= cm_en_ff;
			end
			else if (avs_address == OFS_CTL)
			begin
				rdata_ff[3:0]    <= ctl_ff;
				rdata_ff[ST_CFG] <= cfg_ff;
				rdata_ff[ST_WDF] <= wd_ff != WD_RUN;
				rdata_ff[ST_CMF] <= cm_ff != CM_OK;
				rdata_ff[ST_PIN] <= pin_s2_ff;
			end
		end
	end

	// Synchronisers for the instruction clock and the fault pin
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ic_s1_ff  <= 1'b0;
			ic_s2_ff  <= 1'b0;
			ic_s3_ff  <= 1'b0;
			pin_s1_ff <= 1'b1;
			pin_s2_ff <= 1'b1;
		end
		else if (ce)
		begin
			ic_s1_ff  <= inst_clk_i;
			ic_s2_ff  <= ic_s1_ff;
			ic_s3_ff  <= ic_s2_ff;
			pin_s1_ff <= fault_pin_i;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// Configuration: fixed once by the first keyed write
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			win_ff   <= WIN_RST;
			cm_en_ff <= CM_EN_RST;
			cfg_ff   <= 1'b0;
		end
		else if (ce && svc_valid && !cfg_ff)
		begin
			win_ff   <= avs_writedata[SVC_WIN_LSB +: 2];
			cm_en_ff <= avs_writedata[SVC_CM_BIT];
			cfg_ff   <= 1'b1;
		end
	end

	// Low-power mode and oscillator option bits
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ctl_ff <= CTL_RST;
		else if (ce && ctl_wr)
			ctl_ff <= avs_writedata[3:0];
	end

	// Window counter, frozen in low-power modes and saturating at the limit
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_ff <= 17'h0;
		else if (ce)
		begin
			if (restart)
				cnt_ff <= 17'h0;
			else if (wd_ff == WD_RUN && !susp && tick && !timeout)
				cnt_ff <= cnt_ff + 17'h1;
		end
	end

	// Watchdog fault sequence
	always_comb
	begin
		nxt_wd = wd_ff;
		case (wd_ff)
			WD_RUN:
				if (!susp && (svc_err || timeout))
					nxt_wd = WD_DRIVE;
			WD_DRIVE:
				if (tick && pin_low && wd_hold_ff == HOLD_TC - 5'h1)
					nxt_wd = WD_WAITHI;
			WD_WAITHI:
				if (!pin_low)
					nxt_wd = WD_RUN;
			default:
				nxt_wd = WD_RUN;
		endcase
	end

	// Hold count starts only once the pin is seen low
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wd_ff      <= WD_RUN;
			wd_hold_ff <= 5'h0;
		end
		else if (ce)
		begin
			wd_ff <= nxt_wd;
			if (wd_ff != WD_DRIVE)
				wd_hold_ff <= 5'h0;
			else if (tick && pin_low)
				wd_hold_ff <= wd_hold_ff + 5'h1;
		end
	end

	// Clock gap counter; our clock keeps running through halt
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			gap_ff <= '0;
		else if (ce)
		begin
			if (tick)
				gap_ff <= '0;
			else if (!cm_slow)
				gap_ff <= gap_ff + CMW'(1);
		end
	end

	// Clock monitor fault sequence
	always_comb
	begin
		nxt_cm = cm_ff;
		case (cm_ff)
			CM_OK:
				if (cm_en_ff && cm_slow)
					nxt_cm = CM_FAULT;
			CM_FAULT:
				if (!cm_en_ff)
					nxt_cm = CM_OK;
				else if (!cm_slow)
					nxt_cm = CM_HOLD;
			CM_HOLD:
				if (!cm_en_ff)
					nxt_cm = CM_OK;
				else if (cm_slow)
					nxt_cm = CM_FAULT;
				else if (tick && cm_hold_ff == HOLD_TC - 5'h1)
					nxt_cm = CM_OK;
			default:
				nxt_cm = CM_OK;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cm_ff      <= CM_OK;
			cm_hold_ff <= 5'h0;
		end
		else if (ce)
		begin
			cm_ff <= nxt_cm;
			if (cm_ff != CM_HOLD)
				cm_hold_ff <= 5'h0;
			else if (tick)
				cm_hold_ff <= cm_hold_ff + 5'h1;
		end
	end

	// Shared open-drain driver; either source pulls low
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			oe_ff    <= 1'b0;
			pin_o_ff <= 1'b0;
		end
		else if (ce)
		begin
			oe_ff    <= (nxt_wd == WD_DRIVE) | (nxt_cm != CM_OK);
			pin_o_ff <= 1'b0;
		end
	end

	// Checks
	AST_ARM: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> win_ff == WIN_RST && cm_en_ff && !cfg_ff)
		else $error("not armed after reset");
	AST_UPPER: assert property (@(posedge clk) disable iff (rst)
		ce && wd_ff == WD_RUN && !susp && cnt_ff >= upper_lim(win_ff)
		|=> wd_ff == WD_DRIVE && oe_ff)
		else $error("timeout not flagged");
	AST_BADKEY: assert property (@(posedge clk) disable iff (rst)
		ce && svc_wr && !susp && !key_ok |=> wd_ff == WD_DRIVE)
		else $error("bad key not flagged");
	AST_EARLY: assert property (@(posedge clk) disable iff (rst)
		ce && svc_wr && !susp && cfg_ff && cnt_ff < LOWER_TC |=> oe_ff)
		else $error("early service not flagged");
	AST_FIRST: assert property (@(posedge clk) disable iff (rst)
		ce && svc_wr && !cfg_ff && key_ok
		|=> cfg_ff && cnt_ff == 17'h0 && wd_ff == WD_RUN)
		else $error("first service mishandled");
	AST_IGNORE: assert property (@(posedge clk) disable iff (rst)
		ce && wd_ff != WD_RUN |=> $stable(win_ff) && $stable(cfg_ff))
		else $error("service taken during fault");
	AST_READKEY: assert property (@(posedge clk) disable iff (rst)
		ce && avs_read && wait_ff && avs_address == OFS_SVC
		|=> rdata_ff[5:1] == 5'h0 && !avs_waitrequest)
		else $error("key visible on read");
	AST_CMF: assert property (@(posedge clk) disable iff (rst)
		ce && cm_en_ff && cm_slow |=> cm_ff != CM_OK ##0 oe_ff)
		else $error("slow clock not flagged");
	AST_IDLEX: assert property (@(posedge clk) disable iff (rst)
		ce && idle_exit |=> cnt_ff == 17'h0)
		else $error("idle exit no service");
	AST_RELEASE: assert property (@(posedge clk) disable iff (rst)
		ce && wd_ff == WD_DRIVE && nxt_wd == WD_WAITHI && cm_ff == CM_OK
		&& nxt_cm == CM_OK |=> !oe_ff)
		else $error("pin not released");
	AST_RESUME: assert property (@(posedge clk) disable iff (rst)
		ce && halt_exit && !ctl_ff[CTL_XTAL] && !ctl_ff[CTL_CLOCK_DELAY_SEL] && !idle_exit
		&& wd_ff == WD_RUN |=> cnt_ff == $past(cnt_ff))
		else $error("count not resumed after halt");
	AST_HALTRST: assert property (@(posedge clk) disable iff (rst)
		ce && halt_exit && (ctl_ff[CTL_XTAL] || ctl_ff[CTL_CLOCK_DELAY_SEL]) |=> cnt_ff == 17'h0)
		else $error("window not restarted after halt");
	C_HALTRST: cover property (@(posedge clk) disable iff (rst)
		ce && halt_exit && ctl_ff[CTL_XTAL]);
	C_VALID: cover property (@(posedge clk) disable iff (rst)
		ce && svc_valid && cfg_ff);
	C_TIMEOUT: cover property (@(posedge clk) disable iff (rst)
		ce && wd_ff == WD_RUN && nxt_wd == WD_DRIVE && timeout);
	C_CMREC: cover property (@(posedge clk) disable iff (rst)
		ce && cm_ff == CM_HOLD && nxt_cm == CM_OK);
endmodule : wdcm_top

//--- wdcm_pkg.sv
// Constants and types for the windowed watchdog with clock monitor
package wdcm_pkg;
	// Register byte offsets
	localparam logic [3:0]  OFS_SVC      = 4'h0;
	localparam logic [3:0]  OFS_CTL      = 4'h4;
	// Service register layout and reset values
	localparam logic [4:0]  SVC_KEY      = 5'h0c;
	localparam int          SVC_CM_BIT   = 0;
	localparam int          SVC_KEY_LSB  = 1;
	localparam int          SVC_WIN_LSB  = 6;
	localparam logic [1:0]  WIN_RST      = 2'h3;
	localparam logic        CM_EN_RST    = 1'b1;
	// Control and status register layout
	localparam int          CTL_HALT     = 0;
	localparam int          CTL_IDLE     = 1;
	localparam int          CTL_CLOCK_DELAY_SEL   = 2;
	localparam int          CTL_XTAL     = 3;
	localparam int          ST_CFG       = 8;
	localparam int          ST_WDF       = 9;
	localparam int          ST_CMF       = 10;
	localparam int          ST_PIN       = 11;
	localparam logic [3:0]  CTL_RST      = 4'h0;
	// Window limits in instruction cycles
	localparam logic [16:0] LOWER_TC     = 17'h00800;
	localparam logic [16:0] UPPER_BASE   = 17'h02000;
	localparam logic [4:0]  HOLD_TC      = 5'h10;
	// Clock monitor reject time, between the 10 kHz and 10 Hz periods
	localparam int          CLK_MHZ      = 200;
	localparam int          CM_TIME_US   = 1000;
	localparam int          CM_CYC       = CM_TIME_US * CLK_MHZ;
	typedef enum logic [2:0] {
		WD_RUN    = 3'b001,
		WD_DRIVE  = 3'b010,
		WD_WAITHI = 3'b100
	} wdcm_wd_t;
	typedef enum logic [2:0] {
		CM_OK    = 3'b001,
		CM_FAULT = 3'b010,
		CM_HOLD  = 3'b100
	} wdcm_cm_t;
endpackage : wdcm_pkg

//--- wdcm_pin_model.sv
// Fault pin pull-up and instruction clock source for the watchdog bench
`timescale 1ns/10ps
module wdcm_pin_model (
	input  wire logic clk,
	input  wire logic run,
	input  wire logic pin_o,
	input  wire logic pin_oe,
	output logic      inst_clk,
	output logic      pin
);
	logic [1:0] div_ff = 2'h0;
	// Four clk periods per cycle; stands still while run is low
	always_ff @(posedge clk)
	begin
		if (run)
			div_ff <= div_ff + 2'h1;
	end
	assign inst_clk = div_ff[1];
	// Released pin is pulled high, so no stale driven level survives
	assign pin = pin_oe ? pin_o : 1'b1;
endmodule : wdcm_pin_model

//--- test_wdcm_top.sv
// Self-checking bench for the windowed watchdog and clock monitor
`timescale 1ns/10ps
module test_wdcm_top;
	import wdcm_pkg::*;
	localparam int CMC = 64;
	logic        clk, rst, ce, avs_read, avs_write, avs_waitrequest;
	logic        run, inst_clk, pin, fault_pin_o, fault_pin_oe;
	logic [3:0]  avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rd;
	int          err_total, samples_checked;

	wdcm_top #(.CM_CYC_P(CMC)) i_wdcm_top (.clk(clk), .rst(rst), .ce(ce),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.inst_clk_i(inst_clk), .fault_pin_i(pin), .fault_pin_o(fault_pin_o),
		.fault_pin_oe(fault_pin_oe));
	wdcm_pin_model i_wdcm_pin_model (.clk(clk), .run(run), .pin_o(fault_pin_o),
		.pin_oe(fault_pin_oe), .inst_clk(inst_clk), .pin(pin));

	// Compare and count
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Avalon-MM access; request held until the edge that sees waitrequest low
	task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= {24'h0, d};
		avs_write     <= wr;
		avs_read      <= !wr;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask : bus

	// Let n instruction cycles pass; report whether the pin was pulled
	task quiet(input int n, input string what);
		logic hit;
		hit = 1'b0;
		repeat (n)
		begin
			@(posedge inst_clk);
			#1;
			if (fault_pin_oe !== 1'b0)
				hit = 1'b1;
		end
		chk(what, {31'h0, hit}, 32'h0);
	endtask : quiet

	// Expect the pin driven within lim clk, then measure its hold in cycles
	task fault(input int lim, input string what);
		int n;
		n = 0;
		while (fault_pin_oe !== 1'b1 && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		chk(what, {31'h0, fault_pin_oe}, 32'h1);
		chk("pin low", {31'h0, fault_pin_o}, 32'h0);
		n = 0;
		while (fault_pin_oe === 1'b1 && n < 60)
		begin
			@(posedge inst_clk);
			#1;
			n++;
		end
		chk("hold", {31'h0, n >= 16 && n <= 32}, 32'h1);
		repeat (10) @(negedge clk);
	endtask : fault

	task t_reset;
		chk("oe at reset", {31'h0, fault_pin_oe}, 32'h0);
		bus(1'b0, OFS_SVC, 8'h00);
		chk("svc reset", rd, 32'hc1);
		bus(1'b0, 4'h8, 8'h00);
		chk("unmapped", rd, 32'h0);
		$display("reset test done");
	endtask : t_reset

	// Early keyed configuration: 8k window, monitor on
	task t_config;
		bus(1'b1, OFS_SVC, 8'h19);
		quiet(50, "first service");
		bus(1'b0, OFS_SVC, 8'h00);
		chk("svc read", rd, 32'h01);
		bus(1'b0, OFS_CTL, 8'h00);
		chk("status", rd, 32'h900);
		$display("config test done");
	endtask : t_config

	// Stopped clock in halt must still be caught by the monitor
	task t_clock;
		bus(1'b1, OFS_CTL, 8'h01);
		run <= 1'b0;
		repeat (CMC + 30) @(negedge clk);
		chk("clock fault", {31'h0, fault_pin_oe}, 32'h1);
		run <= 1'b1;
		fault(10, "clock release");
		bus(1'b1, OFS_CTL, 8'h00);
		bus(1'b1, OFS_SVC, 8'h19);
		fault(20, "early service");
		$display("clock and early test done");
	endtask : t_clock

	// One bad field at a time, each inside the legal window
	task t_bad;
		logic [7:0] bad [3];
		bad = '{8'h1b, 8'h59, 8'h18};
		foreach (bad[i])
		begin
			quiet(2100, "window");
			bus(1'b1, OFS_SVC, bad[i]);
			fault(20, "mismatch");
		end
		$display("mismatch test done");
	endtask : t_bad

	// Valid service, then idle exit acts as a service of its own
	task t_valid;
		quiet(2100, "window");
		bus(1'b1, OFS_SVC, 8'h19);
		quiet(2100, "valid service");
		bus(1'b1, OFS_CTL, 8'h02);
		bus(1'b1, OFS_CTL, 8'h00);
		bus(1'b1, OFS_SVC, 8'h19);
		fault(20, "idle exit");
		$display("valid and idle test done");
	endtask : t_valid

	// Halt freezes the count; crystal option restarts it on exit
	task t_halt;
		bus(1'b1, OFS_CTL, 8'h01);
		quiet(2100, "in halt");
		bus(1'b1, OFS_CTL, 8'h00);
		bus(1'b1, OFS_SVC, 8'h19);
		fault(20, "halt resume");
		quiet(2100, "before halt");
		bus(1'b1, OFS_CTL, 8'h09);
		bus(1'b1, OFS_CTL, 8'h08);
		bus(1'b1, OFS_SVC, 8'h19);
		fault(20, "halt restart");
		quiet(8000, "after halt");
		fault(1400, "timeout");
		$display("halt and timeout test done");
	endtask : t_halt

	task conclude;
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial
	begin
		#800us;
		err_total++;
		$display("watchdog expired");
		conclude();
	end

	initial
	begin
		err_total = 0;
		samples_checked = 0;
		rst = 1'b1;
		ce = 1'b1;
		run = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_config();
		t_clock();
		t_bad();
		t_valid();
		t_halt();
		conclude();
	end
endmodule : test_wdcm_top
